/* core/dynamic_ram_controller.sv */
// dynamic ram controller sequencer, refresh timer and address mux
// assumes asynchronous cpu pins, straps stable after reset
`timescale 1ns/1ps
`include "dram_ctrl_consts.svh"
module dynamic_ram_controller #(
	parameter int REF_LONG = `REF_LONG_CYC,
	parameter int REF_SHORT = `REF_SHORT_CYC,
	parameter int AW = 7
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic read_request_n,
	input wire logic write_request_n,
	input wire logic external_refresh_request,
	input wire logic protected_select_n,
	input wire logic advanced_read_strap,
	input wire logic short_refresh_strap,
	input wire logic bank_select_lo,
	input wire logic bank_select_hi,
	input wire logic [AW-1:0] row_address_in,
	input wire logic [AW-1:0] column_address_in,
	output logic [AW-1:0] memory_address_out_n,
	output logic [3:0] row_strobe_n,
	output logic column_strobe_n,
	output logic write_enable_n,
	output logic system_ack_n,
	output logic transfer_ack_n
);
	dram_req_if req ();
	req_sync u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.rd_pin(~read_request_n),
		.wr_pin(~write_request_n),
		.ref_pin(external_refresh_request),
		.req(req)
	);
	dram_ctrl_pkg::state_t state, next_state;
	logic [2:0] step;
	logic [7:0] ref_row;
	logic [15:0] timer;
	logic int_ref_pend, ext_ref_pend, delay_ack, adv_pend, ext_prev;
	logic rd_prev, wr_prev;
	wire logic [15:0] limit;
	wire logic sel, test_req, rd_edge, wr_edge, adv_req, mem_rd, mem_wr, ref_pend;
	wire logic cyc_done, ext_start;
	wire logic [1:0] bank;
	wire logic [3:0] bank_strobe;
	function automatic logic [3:0] decode_bank(input logic [1:0] b);
		decode_bank = 4'h1 << b;
	endfunction : decode_bank
	assign limit = short_refresh_strap ? 16'(REF_SHORT) : 16'(REF_LONG);
	assign sel = ~protected_select_n;
	assign test_req = req.rd & req.wr & ~advanced_read_strap;
	assign rd_edge = req.rd & ~rd_prev;
	assign wr_edge = req.wr & ~wr_prev;
	assign adv_req = req.ale_fall & req.rd & sel;
	assign mem_rd = advanced_read_strap ? adv_pend : (req.rd & sel & ~req.wr);
	assign mem_wr = req.wr & sel & ~req.rd;
	assign ext_start = req.ext_ref & ~ext_prev & ~advanced_read_strap;
	assign ref_pend = int_ref_pend | ext_ref_pend;
	assign cyc_done = (state == dram_ctrl_pkg::st_refresh) ? (step == `T_REF_END) :
		(step == `T_END);
	assign bank = advanced_read_strap ? {1'b1, bank_select_lo} : {bank_select_hi, bank_select_lo};
	assign bank_strobe = decode_bank(bank);
	always_comb begin
		next_state = state;
		case (state)
			dram_ctrl_pkg::st_idle: begin
				if (test_req && (rd_edge || wr_edge))
					next_state = dram_ctrl_pkg::st_test;
				else if (mem_wr && wr_edge)
					next_state = dram_ctrl_pkg::st_write;
				else if (mem_rd && (rd_edge || advanced_read_strap))
					next_state = dram_ctrl_pkg::st_read;
				else if (ref_pend)
					next_state = dram_ctrl_pkg::st_refresh;
			end
			dram_ctrl_pkg::st_test: next_state = dram_ctrl_pkg::st_write;
			dram_ctrl_pkg::st_refresh, dram_ctrl_pkg::st_read, dram_ctrl_pkg::st_write: begin
				if (cyc_done)
					next_state = dram_ctrl_pkg::st_idle;
			end
			default: next_state = dram_ctrl_pkg::st_idle;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state <= dram_ctrl_pkg::st_idle;
			step <= 3'h0;
			rd_prev <= 1'b0;
			wr_prev <= 1'b0;
		end else begin
			state <= next_state;
			step <= (next_state != state) ? 3'h0 : step + 3'h1;
			rd_prev <= (state == dram_ctrl_pkg::st_idle) ? req.rd : rd_prev & req.rd;
			wr_prev <= (state == dram_ctrl_pkg::st_idle) ? req.wr : wr_prev & req.wr;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			timer <= 16'h0000;
			int_ref_pend <= 1'b0;
			ext_ref_pend <= 1'b0;
			adv_pend <= 1'b0;
			delay_ack <= 1'b0;
			ref_row <= 8'h00;
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= req.ext_ref;
			if (ext_start || timer >= limit - 16'h0001)
				timer <= 16'h0000;
			else
				timer <= timer + 16'h0001;
			if (timer >= limit - 16'h0001 && !ext_start)
				int_ref_pend <= 1'b1;
			else if (state == dram_ctrl_pkg::st_refresh && cyc_done)
				int_ref_pend <= 1'b0;
			if (ext_start)
				ext_ref_pend <= 1'b1;
			else if (state == dram_ctrl_pkg::st_refresh && cyc_done)
				ext_ref_pend <= 1'b0;
			if (adv_req)
				adv_pend <= 1'b1;
			else if (state == dram_ctrl_pkg::st_read)
				adv_pend <= 1'b0;
			if (state == dram_ctrl_pkg::st_refresh && (req.rd || adv_req))
				delay_ack <= 1'b1;
			else if (state == dram_ctrl_pkg::st_read && cyc_done)
				delay_ack <= 1'b0;
			if (state == dram_ctrl_pkg::st_test)
				ref_row <= 8'h00;
			else if (state == dram_ctrl_pkg::st_refresh && cyc_done)
				ref_row <= ref_row + 8'h01;
		end
	end
	wire logic is_mem, is_ref, col_phase, we_on;
	assign is_mem = (state == dram_ctrl_pkg::st_read) || (state == dram_ctrl_pkg::st_write);
	assign is_ref = state == dram_ctrl_pkg::st_refresh;
	assign col_phase = step >= `T_COL;
	assign we_on = (state == dram_ctrl_pkg::st_write) && step >= `T_ROW;
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			memory_address_out_n <= '1;
			row_strobe_n <= 4'hF;
			column_strobe_n <= 1'b1;
			write_enable_n <= 1'b1;
			system_ack_n <= 1'b1;
			transfer_ack_n <= 1'b1;
		end else begin
			if (is_ref)
				memory_address_out_n <= ~ref_row[AW-1:0];
			else if (is_mem && col_phase)
				memory_address_out_n <= ~column_address_in;
			else
				memory_address_out_n <= ~row_address_in;
			row_strobe_n <= is_ref ? 4'h0 :
				(is_mem && step >= `T_ROW ? ~bank_strobe : 4'hF);
			column_strobe_n <= ~(is_mem && step > `T_COL);
			write_enable_n <= ~we_on;
			system_ack_n <= ~(is_mem && (delay_ack ? step >= `T_ACK : 1'b1));
			transfer_ack_n <= ~(is_mem && step >= `T_ACK);
		end
	end
endmodule : dynamic_ram_controller

/* inc/dram_ctrl_consts.svh */
// constants for the dynamic ram controller
// assumes one 20 mhz core clock
// What this block does
// - all outputs change on the core clock
// - advanced read: status line and latch strobe
// - short refresh strap selects 64-row interval
// - timer requests refresh; external refresh restarts it
// - refresh row counter advances after each refresh
// - row address first, then column address
// - refresh drives counter, row strobe only
// - address outputs are inverted
// - memory requests beat refresh requests
// - requests synchronised and held pending
// - exactly one of five states
// - read plus write runs test cycle
// - refresh asserts all row strobes only
// - internal refresh every 15.6 us, or every 31.2 us with short refresh strap
// - external refresh latched, starts only when idle
// - refresh runs right after memory cycle
// - latch strobe counts only with status high
// - read during refresh delays system acknowledge
// - chip select gates read and write requests, not test requests, cycles complete
// - bank selects pick one row strobe
// - system acknowledge asserts at cycle start
// - early write, no write enable on reads
`ifndef DRAM_CTRL_CONSTS_SVH
`define DRAM_CTRL_CONSTS_SVH
`define CLK_MHZ 20
`define REF_LONG_NS 15600
`define REF_SHORT_NS 31200
`define REF_LONG_CYC ((`REF_LONG_NS * `CLK_MHZ) / 1000)
`define REF_SHORT_CYC ((`REF_SHORT_NS * `CLK_MHZ) / 1000)
`define T_ROW 3'h1
`define T_COL 3'h2
`define T_ACK 3'h4
`define T_END 3'h5
`define T_REF_END 3'h4
`endif

/* inc/dram_ctrl_pkg.sv */
// types for the dynamic ram controller
// assumes the consts header is included where needed
package dram_ctrl_pkg;
	typedef enum logic [2:0] {st_idle, st_test, st_refresh, st_read, st_write} state_t;
endpackage : dram_ctrl_pkg

/* inc/dram_req_if.sv */
// request bundle from the synchroniser to the sequencer
// assumes both ends on core_clk
`timescale 1ns/1ps
interface dram_req_if;
	logic rd;
	logic wr;
	logic ext_ref;
	logic ale_fall;
	modport sync (output rd, output wr, output ext_ref, output ale_fall);
	modport seq (input rd, input wr, input ext_ref, input ale_fall);
endinterface : dram_req_if

/* core/req_sync.sv */
// three-stage synchronisers for the asynchronous request pins
// assumes pins are active high levels here
`timescale 1ns/1ps
module req_sync (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic rd_pin,
	input wire logic wr_pin,
	input wire logic ref_pin,
	dram_req_if.sync req
);
	logic [2:0] s_rd, s_wr, s_ref;
	logic ref_prev;
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_rd <= 3'h0;
			s_wr <= 3'h0;
			s_ref <= 3'h0;
			req.rd <= 1'b0;
			req.wr <= 1'b0;
			req.ext_ref <= 1'b0;
			ref_prev <= 1'b0;
		end else begin
			s_rd <= {s_rd[1:0], rd_pin};
			s_wr <= {s_wr[1:0], wr_pin};
			s_ref <= {s_ref[1:0], ref_pin};
			if (s_rd[1] == s_rd[2])
				req.rd <= s_rd[2];
			if (s_wr[1] == s_wr[2])
				req.wr <= s_wr[2];
			if (s_ref[1] == s_ref[2])
				req.ext_ref <= s_ref[2];
			ref_prev <= req.ext_ref;
		end
	end
	assign req.ale_fall = ref_prev & ~req.ext_ref;
endmodule : req_sync

/* dv/dram_ctrl_props.sv */
// port assertions for the dynamic ram controller
// assumes addresses held steady through each cycle
`timescale 1ns/1ps
module dram_ctrl_props #(
	parameter int AW = 7
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [AW-1:0] row_address_in,
	input wire logic [AW-1:0] column_address_in,
	input wire logic [AW-1:0] memory_address_out_n,
	input wire logic [3:0] row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_enable_n,
	input wire logic system_ack_n,
	input wire logic transfer_ack_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_cas_wait;
		column_strobe_n [*2];
	endsequence
	sequence s_bank_open;
		$fell(&row_strobe_n) && (row_strobe_n != 4'h0);
	endsequence
	property p_ref_only;
		(row_strobe_n == 4'h0) |-> column_strobe_n && write_enable_n && system_ack_n && transfer_ack_n;
	endproperty
	property p_row_addr;
		s_bank_open |-> memory_address_out_n == ~row_address_in;
	endproperty
	property p_col_addr;
		$fell(column_strobe_n) |-> memory_address_out_n == ~column_address_in;
	endproperty
	property p_one_bank;
		!column_strobe_n |-> $onehot(~row_strobe_n);
	endproperty
	property p_early_we;
		$fell(write_enable_n) |-> s_cas_wait;
	endproperty
	property p_transfer_ack_n;
		$fell(column_strobe_n) |=> $fell(transfer_ack_n);
	endproperty
	property p_system_ack_n;
		$fell(system_ack_n) |-> ##[0:1] (row_strobe_n != 4'hF);
	endproperty
	property p_ack_end;
		$rose(transfer_ack_n) |-> $rose(system_ack_n);
	endproperty
	a_ref_only: assert property (p_ref_only) else $error("refresh drove more than row strobes");
	a_row_addr: assert property (p_row_addr) else $error("row address wrong");
	a_col_addr: assert property (p_col_addr) else $error("column address wrong");
	a_one_bank: assert property (p_one_bank) else $error("more than one bank open");
	a_early_we: assert property (p_early_we) else $error("write enable not early");
	a_transfer_ack_n: assert property (p_transfer_ack_n) else $error("transfer ack late");
	a_system_ack_n: assert property (p_system_ack_n) else $error("system ack outside a cycle");
	a_ack_end: assert property (p_ack_end) else $error("acks did not end together");
endmodule : dram_ctrl_props
bind dynamic_ram_controller dram_ctrl_props #(.AW(AW)) props (.*);

/* dv/dram_array_model.sv */
// dram array model recording strobed addresses
// assumes inverted address outputs from the controller
`timescale 1ns/1ps
module dram_array_model (
	input wire logic core_clk,
	input wire logic [6:0] memory_address_out_n,
	input wire logic [3:0] row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_enable_n
);
	logic [6:0] row, col, ref_row;
	logic [3:0] bank, prev_rs = 4'hF;
	logic wrote, prev_cs = 1'b1;
	int ref_count = 0;
	time cas_at = 0, ref_at = 0;
	always @(posedge core_clk) begin
		prev_rs <= row_strobe_n;
		prev_cs <= column_strobe_n;
		if (prev_rs == 4'hF && row_strobe_n == 4'h0) begin
			ref_row <= ~memory_address_out_n;
			ref_count <= ref_count + 1;
			ref_at <= $time;
		end else if (prev_rs == 4'hF && row_strobe_n != 4'hF) begin
			row <= ~memory_address_out_n;
			bank <= ~row_strobe_n;
		end
		if (prev_cs && !column_strobe_n) begin
			col <= ~memory_address_out_n;
			wrote <= !write_enable_n;
			cas_at <= $time;
		end
	end
endmodule : dram_array_model

/* dv/tb_dynamic_ram_controller.sv */
// bench for the dynamic ram controller
// assumes array model and bound checker
`timescale 1ns/1ps
module tb_dynamic_ram_controller;
	localparam int REF_LONG = 40;
	logic core_clk = 0, rstn = 0, rd_n = 1, wr_n = 1, ref_rq = 0, sel_n = 0;
	logic adv = 0, short_s = 0;
	logic [1:0] bank = 2'h0;
	logic [6:0] row_a = 7'h00, col_a = 7'h00, addr_n;
	logic [3:0] rs_n;
	logic cs_n, we_n, system_ack_n_n, transfer_ack_n_n;
	int fails = 0, samples_checked = 0, cyc = 0, n;
	time t0;
	initial forever #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end
	dynamic_ram_controller #(.REF_LONG(REF_LONG), .REF_SHORT(2 * REF_LONG)) dut (
		.core_clk(core_clk), .rstn(rstn), .read_request_n(rd_n), .write_request_n(wr_n),
		.external_refresh_request(ref_rq), .protected_select_n(sel_n),
		.advanced_read_strap(adv), .short_refresh_strap(short_s),
		.bank_select_lo(bank[0]), .bank_select_hi(bank[1]), .row_address_in(row_a),
		.column_address_in(col_a), .memory_address_out_n(addr_n), .row_strobe_n(rs_n),
		.column_strobe_n(cs_n), .write_enable_n(we_n), .system_ack_n(system_ack_n_n),
		.transfer_ack_n(transfer_ack_n_n));
	dram_array_model ram (.core_clk(core_clk), .memory_address_out_n(addr_n),
		.row_strobe_n(rs_n), .column_strobe_n(cs_n), .write_enable_n(we_n));
	task step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : step
	task check(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task wait_ack();
		for (n = 0; n < 40 && transfer_ack_n_n !== 1'b0; n++) step(1);
		check("transfer ack", 8'h00, {7'h00, transfer_ack_n_n});
		check("system ack", 8'h00, {7'h00, system_ack_n_n});
	endtask : wait_ack
	task mem_cycle(input logic rd, input logic wr);
		rd_n = !rd;
		wr_n = !wr;
		wait_ack();
		rd_n = 1'b1;
		wr_n = 1'b1;
		step(8);
	endtask : mem_cycle
	task wait_ref();
		t0 = ram.ref_at;
		for (n = 0; n < 200 && ram.ref_at == t0; n++) step(1);
		ref_rq = 1'b0;
		step(8);
	endtask : wait_ref
	task results();
		if (fails == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	initial begin
		step(16);
		rstn = 1'b1;
		step(2);
		mem_cycle(1'b1, 1'b1);
		ref_rq = 1'b1;
		wait_ref();
		check("refresh row", 8'h00, {1'b0, ram.ref_row});
		ref_rq = 1'b1;
		wait_ref();
		check("refresh row", 8'h01, {1'b0, ram.ref_row});
		for (int b = 0; b < 4; b++) begin
			bank = 2'(b);
			row_a = 7'h15 + 7'(b);
			col_a = 7'h6A - 7'(b);
			mem_cycle(1'b0, 1'b1);
			check("row", {1'b0, row_a}, {1'b0, ram.row});
			check("column", {1'b0, col_a}, {1'b0, ram.col});
			check("bank", 8'h01 << b, {4'h0, ram.bank});
			check("write", 8'h01, {7'h00, ram.wrote});
		end
		ref_rq = 1'b1;
		mem_cycle(1'b1, 1'b0);
		ref_rq = 1'b0;
		check("read", 8'h00, {7'h00, ram.wrote});
		check("refresh after read", 8'h01, {7'h00, ram.ref_at > ram.cas_at});
		t0 = ram.cas_at;
		sel_n = 1'b1;
		wr_n = 1'b0;
		step(12);
		check("unselected write", 8'h01, {7'h00, ram.cas_at == t0});
		wr_n = 1'b1;
		sel_n = 1'b0;
		wait_ref();
		t0 = ram.ref_at;
		wait_ref();
		n = int'((ram.ref_at - t0) / 50);
		check("refresh gap", 8'h01, {7'h00, n >= REF_LONG && n <= REF_LONG + 8});
		rstn = 1'b0;
		adv = 1'b1;
		short_s = 1'b1;
		bank = 2'h0;
		step(16);
		rstn = 1'b1;
		step(2);
		wait_ref();
		t0 = ram.ref_at;
		wait_ref();
		n = int'((ram.ref_at - t0) / 50);
		check("short gap", 8'h01, {7'h00, n >= 2 * REF_LONG && n <= 2 * REF_LONG + 8});
		t0 = ram.cas_at;
		rd_n = 1'b0;
		step(6);
		ref_rq = 1'b1;
		step(6);
		ref_rq = 1'b0;
		wait_ack();
		rd_n = 1'b1;
		step(8);
		check("advanced read", 8'h01, {7'h00, ram.cas_at != t0});
		check("advanced bank", 8'h04, {4'h0, ram.bank});
		check("advanced no write", 8'h00, {7'h00, ram.wrote});
		results();
	end
endmodule : tb_dynamic_ram_controller
